// File: rtl/lpc_pkg.sv
// Shared constants, types and helpers of the burst command core
package lpc_pkg;

	localparam int LPC_BANKS  = 4;
	localparam int LPC_BA_W   = 2;
	localparam int LPC_ADDR_W = 11;
	localparam int LPC_COL_W  = 8;
	localparam int LPC_DATA_W = 32;
	localparam int LPC_MASK_W = 4;
	localparam int LPC_BYTE_W = 8;
	localparam int LPC_BEAT_W = 4;
	localparam int LPC_PIPE   = 4;
	localparam int LPC_EXT_W  = 13;

	// Mode word fields
	localparam int MR_BL_LO  = 0;
	localparam int MR_BL_W   = 3;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LO  = 4;
	localparam int MR_CL_W   = 3;
	// Extended mode word fields and the precharge-all address bit
	localparam int EMR_DS_LO = 5;
	localparam int EMR_DS_W  = 3;
	localparam int AP_BIT    = 10;

	localparam logic [LPC_ADDR_W-1:0] MR_RESET  = 11'h022;
	localparam logic [LPC_EXT_W-1:0]  EMR_RESET = 13'h0000;
	localparam logic [MR_CL_W-1:0]    CL_TWO    = 3'h2;
	localparam logic [MR_BL_W-1:0]    BL_MIN    = 3'h1;
	localparam logic [MR_BL_W-1:0]    BL_MAX    = 3'h4;
	// Pipe slot counts the edges before the burst starts; output flop adds one
	localparam logic [1:0]            PIPE_CL2  = 2'h0;
	localparam logic [1:0]            PIPE_CL3  = 2'h1;
	localparam logic [LPC_BA_W-1:0]   BANK_MODE = 2'h0;
	localparam logic [LPC_BA_W-1:0]   BANK_EXT  = 2'h2;

	typedef enum logic [2:0] {
		CMD_NOP   = 3'h0,
		CMD_MODE  = 3'h1,
		CMD_EXT   = 3'h2,
		CMD_ACT   = 3'h3,
		CMD_READ  = 3'h4,
		CMD_WRITE = 3'h5,
		CMD_PRE   = 3'h6,
		CMD_STOP  = 3'h7
	} lpc_cmd_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RUN  = 2'b01
	} lpc_wr_state_t;

	typedef struct packed {
		logic                  cs_n;
		logic                  ras_n;
		logic                  cas_n;
		logic                  we_n;
		logic [LPC_BA_W-1:0]   bank;
		logic [LPC_ADDR_W-1:0] addr;
	} lpc_pins_t;

	typedef struct packed {
		logic                 valid;
		logic                 stop;
		logic [LPC_BA_W-1:0]  bank;
		logic [LPC_COL_W-1:0] col;
	} lpc_slot_t;

	typedef struct packed {
		logic [LPC_DATA_W-1:0] data;
		logic [LPC_MASK_W-1:0] mask;
	} lpc_beat_t;

	function automatic lpc_cmd_t lpc_decode(input lpc_pins_t p);
		lpc_cmd_t c;
		c = CMD_NOP;
		case ({p.cs_n, p.ras_n, p.cas_n, p.we_n})
			4'b0000: begin
				if (p.bank == BANK_EXT)
					c = CMD_EXT;
				else if (p.bank == BANK_MODE)
					c = CMD_MODE;
			end
			4'b0011: c = CMD_ACT;
			4'b0101: c = CMD_READ;
			4'b0100: c = CMD_WRITE;
			4'b0010: c = CMD_PRE;
			4'b0110: c = CMD_STOP;
			default: c = CMD_NOP;
		endcase
		return c;
	endfunction

	// Log2 of burst length; unsupported codes fall back to two beats
	function automatic logic [2:0] lpc_len_log(input logic [MR_BL_W-1:0] code);
		return (code >= BL_MIN && code <= BL_MAX) ? code : BL_MIN;
	endfunction

	function automatic logic [LPC_BEAT_W-1:0] lpc_last_beat(input logic [MR_BL_W-1:0] code);
		logic [4:0] n;
		n = (5'h01 << lpc_len_log(code)) - 5'h01;
		return n[LPC_BEAT_W-1:0];
	endfunction

endpackage

// File: rtl/lpc_burst_addr.sv
// Column address generator for sequential and interleaved bursts
`timescale 1ns/10ps
module lpc_burst_addr (
	input  wire logic [lpc_pkg::LPC_COL_W-1:0]  start,
	input  wire logic [lpc_pkg::LPC_BEAT_W-1:0] beat,
	input  wire logic [lpc_pkg::MR_BL_W-1:0]    len_code,
	input  wire logic                           interleave,
	output logic      [lpc_pkg::LPC_COL_W-1:0]  col
);
	logic [lpc_pkg::LPC_BEAT_W-1:0] mask;
	logic [lpc_pkg::LPC_BEAT_W-1:0] low;

	always_comb begin
		mask = lpc_pkg::lpc_last_beat(len_code);
		if (interleave)
			low = start[lpc_pkg::LPC_BEAT_W-1:0] ^ beat;
		else
			low = start[lpc_pkg::LPC_BEAT_W-1:0] + beat;
		// Upper bits stay put so the burst wraps in its aligned block
		col = {start[lpc_pkg::LPC_COL_W-1:lpc_pkg::LPC_BEAT_W],
			(start[lpc_pkg::LPC_BEAT_W-1:0] & ~mask) | (low & mask)};
	end
endmodule

// File: rtl/lpc_strobe_rx.sv
// Write beat capture on the incoming data strobe
`timescale 1ns/10ps
module lpc_strobe_rx (
	input  wire logic                           strobe_clk,
	input  wire logic                           nrst,
	input  wire logic [lpc_pkg::LPC_DATA_W-1:0] dq_in,
	input  wire logic [lpc_pkg::LPC_MASK_W-1:0] mask_in,
	output lpc_pkg::lpc_beat_t                  beat,
	output logic                                toggle
);
	lpc_pkg::lpc_beat_t beat_reg;
	lpc_pkg::lpc_beat_t beat_next;
	logic               toggle_reg;
	logic               toggle_next;

	// Word is held a full strobe period, far longer than the core sync delay
	always_comb begin
		beat_next   = '{data: dq_in, mask: mask_in};
		toggle_next = ~toggle_reg;
	end

	always_ff @(posedge strobe_clk or negedge nrst) begin
		if (!nrst) begin
			beat_reg   <= '0;
			toggle_reg <= 1'b0;
		end else begin
			beat_reg   <= beat_next;
			toggle_reg <= toggle_next;
		end
	end

	assign beat   = beat_reg;
	assign toggle = toggle_reg;
endmodule

// File: rtl/lpc_core.sv
// Command decode, bank tracking and burst engine of the memory device
`timescale 1ns/10ps
module lpc_core #(
	parameter int COL_W = lpc_pkg::LPC_COL_W
) (
	input  wire logic                                CORE_CLK,
	input  wire logic                                NRST,
	input  wire logic                                CKE,
	input  wire logic                                CS_N,
	input  wire logic                                RAS_N,
	input  wire logic                                CAS_N,
	input  wire logic                                WE_N,
	input  wire logic [lpc_pkg::LPC_BA_W-1:0]        BANK_SEL,
	input  wire logic [lpc_pkg::LPC_ADDR_W-1:0]      ADDR,
	input  wire logic                                STROBE_CLK,
	input  wire logic [lpc_pkg::LPC_DATA_W-1:0]      DQ_IN,
	input  wire logic [lpc_pkg::LPC_MASK_W-1:0]      WRITE_MASK,
	output logic      [lpc_pkg::LPC_DATA_W-1:0]      DQ_OUT,
	output logic                                     DQ_OE,
	output logic                                     STROBE_OUT,
	output logic                                     STROBE_OE,
	output logic      [lpc_pkg::EMR_DS_W-1:0]        DRIVE_STRENGTH,
	output logic      [lpc_pkg::LPC_BANKS-1:0]       BANK_OPEN
);
	if (COL_W < lpc_pkg::LPC_BEAT_W || COL_W > lpc_pkg::LPC_COL_W) begin : g_bad_col
		$error("COL_W out of range");
	end

	localparam int MEM_DEPTH = lpc_pkg::LPC_BANKS << COL_W;

	lpc_pkg::lpc_pins_t pins;
	lpc_pkg::lpc_cmd_t  cmd;
	logic               ap;
	logic               all_idle;
	logic               rd_go;
	logic               wr_go;

	logic [lpc_pkg::LPC_ADDR_W-1:0] mode_reg;
	logic [lpc_pkg::LPC_ADDR_W-1:0] mode_next;
	logic [lpc_pkg::LPC_EXT_W-1:0]  ext_mode_reg;
	logic [lpc_pkg::LPC_EXT_W-1:0]  ext_mode_next;
	logic [lpc_pkg::LPC_BANKS-1:0]  bank_open_reg;
	logic [lpc_pkg::LPC_BANKS-1:0]  bank_open_next;

	logic [lpc_pkg::MR_BL_W-1:0]    len_code;
	logic                           interleave;
	logic [1:0]                     lat_slot;

	lpc_pkg::lpc_slot_t             pipe_reg  [lpc_pkg::LPC_PIPE];
	lpc_pkg::lpc_slot_t             pipe_next [lpc_pkg::LPC_PIPE];

	logic                           rd_active_reg;
	logic                           rd_active_next;
	logic [lpc_pkg::LPC_BA_W-1:0]   rd_bank_reg;
	logic [lpc_pkg::LPC_BA_W-1:0]   rd_bank_next;
	logic [lpc_pkg::LPC_COL_W-1:0]  rd_start_reg;
	logic [lpc_pkg::LPC_COL_W-1:0]  rd_start_next;
	logic [lpc_pkg::LPC_BEAT_W-1:0] rd_beat_reg;
	logic [lpc_pkg::LPC_BEAT_W-1:0] rd_beat_next;
	logic [lpc_pkg::LPC_COL_W-1:0]  rd_col;
	logic [lpc_pkg::LPC_DATA_W-1:0] dq_out_reg;
	logic [lpc_pkg::LPC_DATA_W-1:0] dq_out_next;
	logic                           dq_oe_reg;
	logic                           dq_oe_next;
	logic                           strobe_reg;
	logic                           strobe_next;

	lpc_pkg::lpc_wr_state_t         wr_state_reg;
	lpc_pkg::lpc_wr_state_t         wr_state_next;
	logic [lpc_pkg::LPC_BA_W-1:0]   wr_bank_reg;
	logic [lpc_pkg::LPC_BA_W-1:0]   wr_bank_next;
	logic [lpc_pkg::LPC_COL_W-1:0]  wr_start_reg;
	logic [lpc_pkg::LPC_COL_W-1:0]  wr_start_next;
	logic [lpc_pkg::LPC_BEAT_W-1:0] wr_beat_reg;
	logic [lpc_pkg::LPC_BEAT_W-1:0] wr_beat_next;
	logic [lpc_pkg::LPC_COL_W-1:0]  wr_col;
	logic                           mem_we;

	lpc_pkg::lpc_beat_t             link_beat;
	logic                           link_tog;
	logic                           tog_s1_reg;
	logic                           tog_s2_reg;
	logic                           tog_s3_reg;
	logic                           arrive;

	logic [lpc_pkg::LPC_DATA_W-1:0] mem [MEM_DEPTH];

	function automatic logic [lpc_pkg::LPC_BA_W+COL_W-1:0] mem_idx(
		input logic [lpc_pkg::LPC_BA_W-1:0]  b,
		input logic [lpc_pkg::LPC_COL_W-1:0] c
	);
		return {b, c[COL_W-1:0]};
	endfunction

	// Command decode
	assign pins       = '{cs_n: CS_N, ras_n: RAS_N, cas_n: CAS_N, we_n: WE_N,
		bank: BANK_SEL, addr: ADDR};
	assign cmd        = lpc_pkg::lpc_decode(pins);
	assign ap         = pins.addr[lpc_pkg::AP_BIT];
	assign all_idle   = (bank_open_reg == '0);
	assign rd_go      = (cmd == lpc_pkg::CMD_READ) && bank_open_reg[pins.bank];
	assign wr_go      = (cmd == lpc_pkg::CMD_WRITE) && bank_open_reg[pins.bank];
	assign len_code   = mode_reg[lpc_pkg::MR_BL_LO +: lpc_pkg::MR_BL_W];
	assign interleave = mode_reg[lpc_pkg::MR_BT_BIT];
	assign lat_slot   = (mode_reg[lpc_pkg::MR_CL_LO +: lpc_pkg::MR_CL_W] == lpc_pkg::CL_TWO) ?
		lpc_pkg::PIPE_CL2 : lpc_pkg::PIPE_CL3;

	// Mode words and bank state
	always_comb begin
		mode_next      = mode_reg;
		ext_mode_next  = ext_mode_reg;
		bank_open_next = bank_open_reg;
		case (cmd)
			lpc_pkg::CMD_MODE: begin
				if (all_idle)
					mode_next = pins.addr;
			end
			lpc_pkg::CMD_EXT: begin
				if (all_idle)
					ext_mode_next = {pins.bank, pins.addr};
			end
			lpc_pkg::CMD_ACT: bank_open_next[pins.bank] = 1'b1;
			lpc_pkg::CMD_PRE: begin
				if (ap)
					bank_open_next = '0;
				else
					bank_open_next[pins.bank] = 1'b0;
			end
			default: ;
		endcase
	end

	// Read latency pipe; slot 0 starts or stops the output burst
	always_comb begin
		for (int i = 0; i < lpc_pkg::LPC_PIPE; i++) begin
			pipe_next[i] = (i < lpc_pkg::LPC_PIPE - 1) ? pipe_reg[i + 1] : '0;
		end
		if (rd_go)
			pipe_next[lat_slot] = '{valid: 1'b1, stop: 1'b0, bank: pins.bank,
				col: pins.addr[lpc_pkg::LPC_COL_W-1:0]};
		else if (cmd == lpc_pkg::CMD_STOP)
			pipe_next[lat_slot] = '{valid: 1'b1, stop: 1'b1, bank: '0, col: '0};
	end

	lpc_burst_addr u_rd_addr (
		.start      (rd_start_reg),
		.beat       (rd_beat_reg),
		.len_code   (len_code),
		.interleave (interleave),
		.col        (rd_col)
	);

	always_comb begin
		rd_active_next = rd_active_reg;
		rd_bank_next   = rd_bank_reg;
		rd_start_next  = rd_start_reg;
		rd_beat_next   = rd_beat_reg;
		dq_out_next    = dq_out_reg;
		dq_oe_next     = rd_active_reg;
		strobe_next    = rd_active_reg ? ~strobe_reg : 1'b0;
		if (rd_active_reg)
			dq_out_next = mem[mem_idx(rd_bank_reg, rd_col)];
		if (pipe_reg[0].valid) begin
			// Interrupting burst restarts at full length
			rd_active_next = !pipe_reg[0].stop;
			rd_bank_next   = pipe_reg[0].bank;
			rd_start_next  = pipe_reg[0].col;
			rd_beat_next   = '0;
		end else if (rd_active_reg) begin
			if (rd_beat_reg == lpc_pkg::lpc_last_beat(len_code))
				rd_active_next = 1'b0;
			else
				rd_beat_next = rd_beat_reg + 1'b1;
		end
	end

	// Write burst engine fed by the strobe domain
	lpc_strobe_rx u_strobe_rx (
		.strobe_clk (STROBE_CLK),
		.nrst       (NRST),
		.dq_in      (DQ_IN),
		.mask_in    (WRITE_MASK),
		.beat       (link_beat),
		.toggle     (link_tog)
	);

	assign arrive = tog_s2_reg ^ tog_s3_reg;

	lpc_burst_addr u_wr_addr (
		.start      (wr_start_reg),
		.beat       (wr_beat_reg),
		.len_code   (len_code),
		.interleave (interleave),
		.col        (wr_col)
	);

	always_comb begin
		wr_state_next = wr_state_reg;
		wr_bank_next  = wr_bank_reg;
		wr_start_next = wr_start_reg;
		wr_beat_next  = wr_beat_reg;
		mem_we        = 1'b0;
		if (wr_go) begin
			// A new write overrides what is left of the old one
			wr_state_next = lpc_pkg::WR_RUN;
			wr_bank_next  = pins.bank;
			wr_start_next = pins.addr[lpc_pkg::LPC_COL_W-1:0];
			wr_beat_next  = '0;
		end else begin
			case (wr_state_reg)
				lpc_pkg::WR_RUN: begin
					if (arrive) begin
						mem_we = 1'b1;
						if (wr_beat_reg == lpc_pkg::lpc_last_beat(len_code))
							wr_state_next = lpc_pkg::WR_IDLE;
						else
							wr_beat_next = wr_beat_reg + 1'b1;
					end
				end
				lpc_pkg::WR_IDLE: mem_we = 1'b0;
				default: wr_state_next = lpc_pkg::WR_IDLE;
			endcase
		end
	end

	// Storage has no reset; masked bytes keep their contents
	always_ff @(posedge CORE_CLK) begin
		if (CKE && mem_we) begin
			for (int b = 0; b < lpc_pkg::LPC_MASK_W; b++) begin
				if (!link_beat.mask[b])
					mem[mem_idx(wr_bank_reg, wr_col)][b*lpc_pkg::LPC_BYTE_W +: lpc_pkg::LPC_BYTE_W]
						<= link_beat.data[b*lpc_pkg::LPC_BYTE_W +: lpc_pkg::LPC_BYTE_W];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			mode_reg      <= lpc_pkg::MR_RESET;
			ext_mode_reg  <= lpc_pkg::EMR_RESET;
			bank_open_reg <= '0;
			for (int i = 0; i < lpc_pkg::LPC_PIPE; i++) begin
				pipe_reg[i] <= '0;
			end
			rd_active_reg <= 1'b0;
			rd_bank_reg   <= '0;
			rd_start_reg  <= '0;
			rd_beat_reg   <= '0;
			dq_out_reg    <= '0;
			dq_oe_reg     <= 1'b0;
			strobe_reg    <= 1'b0;
			wr_state_reg  <= lpc_pkg::WR_IDLE;
			wr_bank_reg   <= '0;
			wr_start_reg  <= '0;
			wr_beat_reg   <= '0;
			tog_s1_reg    <= 1'b0;
			tog_s2_reg    <= 1'b0;
			tog_s3_reg    <= 1'b0;
		end else if (CKE) begin
			mode_reg      <= mode_next;
			ext_mode_reg  <= ext_mode_next;
			bank_open_reg <= bank_open_next;
			pipe_reg      <= pipe_next;
			rd_active_reg <= rd_active_next;
			rd_bank_reg   <= rd_bank_next;
			rd_start_reg  <= rd_start_next;
			rd_beat_reg   <= rd_beat_next;
			dq_out_reg    <= dq_out_next;
			dq_oe_reg     <= dq_oe_next;
			strobe_reg    <= strobe_next;
			wr_state_reg  <= wr_state_next;
			wr_bank_reg   <= wr_bank_next;
			wr_start_reg  <= wr_start_next;
			wr_beat_reg   <= wr_beat_next;
			tog_s1_reg    <= link_tog;
			tog_s2_reg    <= tog_s1_reg;
			tog_s3_reg    <= tog_s2_reg;
		end
	end

	assign DQ_OUT         = dq_out_reg;
	assign DQ_OE          = dq_oe_reg;
	assign STROBE_OUT     = strobe_reg;
	assign STROBE_OE      = dq_oe_reg;
	assign DRIVE_STRENGTH = ext_mode_reg[lpc_pkg::EMR_DS_LO +: lpc_pkg::EMR_DS_W];
	assign BANK_OPEN      = bank_open_reg;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	sequence s_read_cl2;
		CKE && rd_go && lat_slot == lpc_pkg::PIPE_CL2 ##1 CKE[*2];
	endsequence

	sequence s_read_cl3;
		CKE && rd_go && lat_slot == lpc_pkg::PIPE_CL3 ##1 CKE[*3];
	endsequence

	a_pre_all_close: assert property (
		CKE && cmd == lpc_pkg::CMD_PRE && ap |=> BANK_OPEN == '0)
		else $error("precharge all left a bank open");

	a_pre_one_close: assert property (
		CKE && cmd == lpc_pkg::CMD_PRE && !ap |=>
			!BANK_OPEN[$past(BANK_SEL)] &&
			((BANK_OPEN | ($past(4'h1) << $past(BANK_SEL))) ==
			($past(BANK_OPEN) | ($past(4'h1) << $past(BANK_SEL)))))
		else $error("single precharge touched the wrong bank");

	a_act_open: assert property (
		CKE && cmd == lpc_pkg::CMD_ACT |=> BANK_OPEN[$past(BANK_SEL)])
		else $error("activate did not open its bank");

	a_ds_capture: assert property (
		CKE && cmd == lpc_pkg::CMD_EXT && all_idle |=>
			DRIVE_STRENGTH == $past(ADDR[7:5]))
		else $error("drive strength not taken from address");

	a_mode_idle_only: assert property (
		!all_idle && (cmd == lpc_pkg::CMD_MODE || cmd == lpc_pkg::CMD_EXT) |=>
			$stable(mode_reg) && $stable(ext_mode_reg))
		else $error("mode word changed with a bank open");

	a_read_cl2_data: assert property (
		s_read_cl2 |=> DQ_OE && STROBE_OE)
		else $error("read data missing after latency two");

	a_read_cl3_data: assert property (
		s_read_cl3 |=> DQ_OE && STROBE_OE)
		else $error("read burst not started after latency three");

	a_write_ignore: assert property (
		wr_state_reg == lpc_pkg::WR_IDLE |-> !mem_we)
		else $error("write beat taken outside a burst");

	a_nop_hold: assert property (
		CKE && cmd == lpc_pkg::CMD_NOP |=> $stable(BANK_OPEN) && $stable(DRIVE_STRENGTH))
		else $error("idle command changed device state");

	a_burst_align: assert property (
		rd_active_reg |-> ((rd_col ^ rd_start_reg) &
			~{{(lpc_pkg::LPC_COL_W-lpc_pkg::LPC_BEAT_W){1'b0}},
			lpc_pkg::lpc_last_beat(len_code)}) == '0)
		else $error("burst column left its aligned block");

endmodule

// File: sim/lpc_ctrl_model.sv
// Controller model: commands at the falling clock edge, strobed write beats
`timescale 1ns/10ps
module lpc_ctrl_model #(
	parameter int ACT_GAP = 3,
	parameter int PRE_GAP = 3
) (
	input  wire logic                      CORE_CLK,
	output logic                           CKE,
	output logic                           CS_N,
	output logic                           RAS_N,
	output logic                           CAS_N,
	output logic                           WE_N,
	output logic [lpc_pkg::LPC_BA_W-1:0]   BANK_SEL,
	output logic [lpc_pkg::LPC_ADDR_W-1:0] ADDR,
	output logic                           STROBE_CLK,
	output logic [lpc_pkg::LPC_DATA_W-1:0] DQ_IN,
	output logic [lpc_pkg::LPC_MASK_W-1:0] WRITE_MASK
);
	lpc_pkg::lpc_pins_t pins;

	assign {CS_N, RAS_N, CAS_N, WE_N, BANK_SEL, ADDR} = pins;

	initial begin
		CKE = 1'b1;
		pins = {4'hf, 2'h0, 11'h000};
		STROBE_CLK = 1'b0;
		DQ_IN = 32'h0;
		WRITE_MASK = 4'h0;
	end

	task automatic cke(input logic v);
		@(negedge CORE_CLK);
		CKE = v;
	endtask

	task automatic cmd(input logic [3:0] code, input logic [1:0] bank,
			input logic [10:0] addr, input int idle);
		@(negedge CORE_CLK);
		pins = {code, bank, addr};
		@(negedge CORE_CLK);
		// No-operation; stale address lines inverted so nothing leans on them
		pins = {4'h7, ~bank, ~addr};
		repeat (idle) @(negedge CORE_CLK);
	endtask

	task automatic act(input logic [1:0] bank);
		cmd(4'h3, bank, 11'h000, ACT_GAP);
	endtask

	task automatic pre(input logic [1:0] bank, input logic all);
		cmd(4'h2, bank, {all, 10'h000}, PRE_GAP);
	endtask

	task automatic ext(input logic [2:0] ds);
		cmd(4'h0, 2'h2, {3'h0, ds, 5'h00}, 2);
	endtask

	task automatic mode(input logic [6:0] word);
		cmd(4'h0, 2'h0, {4'h0, word}, 2);
	endtask

	task automatic wr_burst(input logic [1:0] bank, input logic [7:0] col, input int beats,
			input logic [31:0] base, input int extra);
		cmd(4'h4, bank, {3'h0, col}, 0);
		for (int i = 0; i < beats + extra; i++) begin
			#7;
			DQ_IN = (i < beats) ? base + 32'(i) : ~base;
			#40 STROBE_CLK = 1'b1;
			#80 STROBE_CLK = 1'b0;
			// Bus released after the hold: show the inverse, not the last beat
			#33 DQ_IN = ~DQ_IN;
		end
		repeat (PRE_GAP) @(negedge CORE_CLK);
	endtask
endmodule

// File: sim/lpc_core_test.sv
// Self-checking bench for the burst command core
`timescale 1ns/10ps
module lpc_core_test;
	localparam logic [31:0] BASE = 32'h3c5a0000;
	// Read cases: {read latency, interleave, log2 length, start column}
	localparam logic [14:0] CASES [6] = '{
		{3'h2, 1'b0, 3'h1, 8'h01}, {3'h3, 1'b0, 3'h2, 8'h03}, {3'h2, 1'b0, 3'h3, 8'h0d},
		{3'h2, 1'b1, 3'h2, 8'h01}, {3'h3, 1'b1, 3'h3, 8'h06}, {3'h2, 1'b1, 3'h4, 8'h09}};
	logic                           CORE_CLK = 1'b0;
	logic                           NRST     = 1'b0;
	logic                           CKE, CS_N, RAS_N, CAS_N, WE_N, STROBE_CLK;
	logic [lpc_pkg::LPC_BA_W-1:0]   BANK_SEL;
	logic [lpc_pkg::LPC_ADDR_W-1:0] ADDR;
	logic [lpc_pkg::LPC_DATA_W-1:0] DQ_IN, DQ_OUT;
	logic [lpc_pkg::LPC_MASK_W-1:0] WRITE_MASK;
	logic                           DQ_OE, STROBE_OUT, STROBE_OE;
	logic [lpc_pkg::EMR_DS_W-1:0]   DRIVE_STRENGTH;
	logic [lpc_pkg::LPC_BANKS-1:0]  BANK_OPEN;
	int                             num_errors = 0;
	int                             num_checks = 0;
	int                             k;

	always #5 CORE_CLK = ~CORE_CLK;

	lpc_ctrl_model ctrl_u (.CORE_CLK(CORE_CLK), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
		.CAS_N(CAS_N), .WE_N(WE_N), .BANK_SEL(BANK_SEL), .ADDR(ADDR),
		.STROBE_CLK(STROBE_CLK), .DQ_IN(DQ_IN), .WRITE_MASK(WRITE_MASK));

	lpc_core dut_u (.CORE_CLK(CORE_CLK), .NRST(NRST), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
		.CAS_N(CAS_N), .WE_N(WE_N), .BANK_SEL(BANK_SEL), .ADDR(ADDR),
		.STROBE_CLK(STROBE_CLK), .DQ_IN(DQ_IN), .WRITE_MASK(WRITE_MASK), .DQ_OUT(DQ_OUT),
		.DQ_OE(DQ_OE), .STROBE_OUT(STROBE_OUT), .STROBE_OE(STROBE_OE),
		.DRIVE_STRENGTH(DRIVE_STRENGTH), .BANK_OPEN(BANK_OPEN));

	task automatic give_verdict();
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
			num_errors++;
		end
	endtask

	function automatic logic [7:0] col_of(input logic [7:0] start, input int i,
			input logic [2:0] lg, input logic il);
		logic [7:0] m;
		m = 8'((1 << lg) - 1);
		if (il)
			return (start & ~m) | ((start ^ 8'(i)) & m);
		return (start & ~m) | ((start + 8'(i)) & m);
	endfunction

	// One read beat; strobe starts high and toggles across the whole stream
	task automatic beat(input logic [7:0] col, input int idx);
		check(DQ_OE, 1, "drive enable");
		check(STROBE_OE, 1, "strobe enable");
		check(STROBE_OUT, !idx[0], "read strobe");
		check(DQ_OUT, BASE + col, "read data");
	endtask

	// Mode words only land with every bank idle, so close all first
	task automatic setup(input logic [6:0] word);
		ctrl_u.pre(2'h0, 1'b1);
		ctrl_u.mode(word);
		ctrl_u.act(2'h1);
	endtask

	task automatic rd(input logic [14:0] c);
		setup(c[14:8]);
		ctrl_u.cmd(4'h5, 2'h1, {3'h0, c[7:0]}, 0);
		repeat (c[14:12] - 1) @(negedge CORE_CLK);
		check(DQ_OE, 0, "drive before latency");
		for (int i = 0; i < (1 << c[10:8]); i++) begin
			@(negedge CORE_CLK);
			beat(col_of(c[7:0], i, c[10:8], c[11]), i);
		end
		@(negedge CORE_CLK);
		check(DQ_OE, 0, "drive after burst");
	endtask

	initial begin
		repeat (60000) @(posedge CORE_CLK);
		$display("ERROR %0t run did not finish", $time);
		num_errors++;
		give_verdict();
	end

	initial begin
		repeat (12) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
		NRST = 1'b1;
		check(BANK_OPEN, 0, "banks after reset");
		check(DRIVE_STRENGTH, 0, "strength after reset");
		for (k = 0; k < 4; k++) begin
			ctrl_u.ext(3'(k));
			check(DRIVE_STRENGTH, k, "drive strength");
		end
		ctrl_u.cke(1'b0);
		ctrl_u.act(2'h0);
		ctrl_u.cke(1'b1);
		ctrl_u.cmd(4'hb, 2'h1, 11'h000, 2);
		check(BANK_OPEN, 0, "ignored activates");
		for (k = 0; k < 4; k++)
			ctrl_u.act(2'(k));
		check(BANK_OPEN, 4'hf, "all banks open");
		ctrl_u.ext(3'h1);
		check(DRIVE_STRENGTH, 3, "strength kept while open");
		ctrl_u.pre(2'h2, 1'b0);
		check(BANK_OPEN, 4'hb, "one bank closed");
		ctrl_u.pre(2'h2, 1'b1);
		check(BANK_OPEN, 0, "all banks closed");
		ctrl_u.cmd(4'h5, 2'h2, 11'h000, 2);
		check(DQ_OE, 0, "read of closed bank");
		// Terminate a junk read, then fill columns 0..15 with one extra beat
		setup(7'h2c);
		ctrl_u.cmd(4'h5, 2'h1, 11'h000, 0);
		ctrl_u.cmd(4'h6, 2'h1, 11'h000, 0);
		check(DQ_OE, 1, "read before terminate");
		repeat (2) @(negedge CORE_CLK);
		check(DQ_OE, 0, "terminated read");
		ctrl_u.wr_burst(2'h1, 8'h00, 16, BASE, 1);
		for (k = 0; k < 6; k++)
			rd(CASES[k]);
		setup(7'h22);
		ctrl_u.cmd(4'h5, 2'h1, 11'h000, 0);
		ctrl_u.cmd(4'h5, 2'h1, 11'h00a, 0);
		beat(8'h00, 0);
		@(negedge CORE_CLK);
		beat(8'h01, 1);
		for (k = 0; k < 4; k++) begin
			@(negedge CORE_CLK);
			beat(col_of(8'h0a, k, 3'h2, 1'b0), k + 2);
		end
		@(negedge CORE_CLK);
		check(DQ_OE, 0, "interrupting burst end");
		give_verdict();
	end
endmodule
